// ==== port_a_pkg.sv ====
// Package: register map, field positions and reset values for port A block
package port_a_pkg;

   // ==========================================
   // Register offsets (byte addresses)
   // ==========================================
   localparam logic [7:0] OFS_VALUE     = 8'h00;
   localparam logic [7:0] OFS_LATCH     = 8'h04;
   localparam logic [7:0] OFS_DIRECTION = 8'h08;
   localparam logic [7:0] OFS_PULLUP    = 8'h0c;
   localparam logic [7:0] OFS_ANALOG    = 8'h10;
   localparam logic [7:0] OFS_ALT_SEL1  = 8'h14;
   localparam logic [7:0] OFS_OPTION    = 8'h18;

   // ==========================================
   // Field positions
   // ==========================================
   localparam int INPUT_ONLY_PIN   = 5;
   localparam int PULLUP_PIN       = 5;
   localparam int TX_SEL_BIT       = 0;
   localparam int GLOBAL_PU_BIT    = 7;
   localparam int ANALOG_PINS      = 5;

   // ==========================================
   // Reset values
   // ==========================================
   localparam logic [7:0] DIRECTION_RST = 8'hff;
   localparam logic [7:0] LATCH_RST     = 8'h00;
   localparam logic [7:0] PULLUP_RST    = 8'h00;
   localparam logic [4:0] ANALOG_RST    = 5'h1f;
   localparam logic       ALT_SEL1_RST  = 1'b0;
   localparam logic       GLOBAL_PU_RST = 1'b1;

   // Peripheral output requests, one valid/data pair per source
   typedef struct packed {
      logic en;
      logic val;
   } periph_out_t;

   // Peripheral sources that may drive port A
   typedef struct packed {
      periph_out_t spi_two_data_out;
      periph_out_t spi_two_select;
      periph_out_t dac_output;
      periph_out_t sr_latch_out;
      periph_out_t capture_compare_three;
      periph_out_t comparator_one_out;
      periph_out_t sr_latch_out_inv;
      periph_out_t capture_compare_four;
      periph_out_t timer_zero_clock_in;
      periph_out_t comparator_two_out;
      periph_out_t crystal_out;
      periph_out_t instr_clock_out;
      periph_out_t reference_clock_out;
      periph_out_t spi_one_data_out;
      periph_out_t pwm_one_out_d;
      periph_out_t pwm_two_out_b;
      periph_out_t crystal_in_clock_in;
      periph_out_t pwm_one_out_c;
      periph_out_t capture_compare_two;
      periph_out_t pwm_two_out_a;
   } periph_bundle_t;

   // Serial transmit function request and its port B routing
   typedef struct packed {
      logic drive_en;
      logic val;
   } serial_route_t;

endpackage : port_a_pkg

// ==== port_a_io.sv ====
// Port A general-purpose I/O with output priority and pin-select steering
//
// What this block does
// - Select bit zero steers serial function B2/B5
// - Pin select leaves directions; overrides follow
// - Eight-bit bidirectional port, per-pin direction
// - Direction one turns output driver off
// - Direction zero drives latch onto pin
// - Pin five input only, direction reads one
// - Value read gives pins; write loads latch
// - Port writes replace the latch byte, bit five held clear
// - Direction still governs analog-selected pin drivers
// - Pull-up bit five controls pin five
// - Pull-up forced off while pin outputs
// - Global pull-up disable set after reset
// - Pull-up needs global clear; external reset forces
// - Analog pin reads digital zero
// - Analog select leaves digital output untouched
// - Analog select bits reset to analog
// - Highest-priority enabled output owns the pin
// - Analog inputs connect only in analog mode
// - Peripheral outputs still drive analog pins
// - Pin six priority: crystal, clocks, SPI, PWM
// - Latch read gives latch; write equals value write
`timescale 1ns/10ps

module port_a_io
(
   input  wire logic                      clk_sys,         // System clock, 125 MHz
   input  wire logic                      rst_n,           // Async reset, active low
   input  wire logic                      psel,            // APB select
   input  wire logic                      penable,         // APB access phase
   input  wire logic                      pwrite,          // APB write
   input  wire logic [7:0]                paddr,           // APB byte address
   input  wire logic [31:0]               pwdata,          // APB write data
   output logic      [31:0]               prdata,          // APB read data
   output logic                           pready,          // APB ready
   output logic                           pslverr,         // APB error
   input  wire logic [7:0]                pin_a_in,        // Port A pad levels
   output logic      [7:0]                pin_a_out,       // Port A drive value
   output logic      [7:0]                pin_a_oe,        // Port A driver enable
   output logic      [7:0]                pin_a_pullup,    // Port A weak pull-up on
   output logic      [4:0]                analog_connect,  // Analog input switch on
   input  wire port_a_pkg::periph_bundle_t periph,         // Peripheral outputs
   input  wire logic                      crystal_out_cfg, // Crystal out enabled
   input  wire logic                      crystal_in_cfg,  // Clock input enabled
   input  wire logic                      external_reset_enable, // Reset pin enabled
   input  wire port_a_pkg::serial_route_t serial_transmit_clock, // Serial function
   output port_a_pkg::serial_route_t      pin_b2_override, // Serial override on B2
   output port_a_pkg::serial_route_t      pin_b5_override  // Serial override on B5
);

   // ==========================================
   // Pin input synchroniser
   // ==========================================
   logic [7:0] pin_meta_reg;
   logic [7:0] pin_sync_reg;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_meta_reg <= 8'h00;
         pin_sync_reg <= 8'h00;
      end
      else
      begin
         pin_meta_reg <= pin_a_in;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // ==========================================
   // Register storage
   // ==========================================
   logic [7:0] direction_reg;
   logic [7:0] latch_reg;
   logic       pullup_reg;
   logic [4:0] analog_reg;
   logic       tx_sel_reg;
   logic       global_pu_reg;
   logic [7:0] pin_digital;

   logic wr_en;
   logic rd_setup;
   logic addr_hit;

   logic sel_value;
   logic sel_latch;
   logic sel_direction;
   logic sel_pullup;
   logic sel_analog;
   logic sel_alt;
   logic sel_option;

   assign wr_en    = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;

   // ==========================================
   // Address decode
   // ==========================================
   always_comb
   begin
      sel_value     = 1'b0;
      sel_latch     = 1'b0;
      sel_direction = 1'b0;
      sel_pullup    = 1'b0;
      sel_analog    = 1'b0;
      sel_alt       = 1'b0;
      sel_option    = 1'b0;
      if (paddr == port_a_pkg::OFS_VALUE)
         sel_value = 1'b1;
      else if (paddr == port_a_pkg::OFS_LATCH)
         sel_latch = 1'b1;
      else if (paddr == port_a_pkg::OFS_DIRECTION)
         sel_direction = 1'b1;
      else if (paddr == port_a_pkg::OFS_PULLUP)
         sel_pullup = 1'b1;
      else if (paddr == port_a_pkg::OFS_ANALOG)
         sel_analog = 1'b1;
      else if (paddr == port_a_pkg::OFS_ALT_SEL1)
         sel_alt = 1'b1;
      else if (paddr == port_a_pkg::OFS_OPTION)
         sel_option = 1'b1;
   end

   assign addr_hit = sel_value || sel_latch || sel_direction || sel_pullup
                     || sel_analog || sel_alt || sel_option;

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_hit;

   // ==========================================
   // Register writes
   // ==========================================
   // Direction: pin five held as input
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         direction_reg <= port_a_pkg::DIRECTION_RST;
      else if (wr_en && sel_direction)
      begin
         direction_reg <= pwdata[7:0];
         direction_reg[port_a_pkg::INPUT_ONLY_PIN] <= 1'b1;
      end
   end

   // Latch: value and latch writes both land here
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         latch_reg <= port_a_pkg::LATCH_RST;
      else if (wr_en && (sel_value || sel_latch))
      begin
         // Byte replaced with bit five held clear; a read-modify-write sequence reads pins first
         latch_reg <= pwdata[7:0];
         latch_reg[port_a_pkg::INPUT_ONLY_PIN] <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         pullup_reg <= port_a_pkg::PULLUP_RST[port_a_pkg::PULLUP_PIN];
      else if (wr_en && sel_pullup)
         pullup_reg <= pwdata[port_a_pkg::PULLUP_PIN];
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         analog_reg <= port_a_pkg::ANALOG_RST;
      else if (wr_en && sel_analog)
         analog_reg <= pwdata[4:0];
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         tx_sel_reg <= port_a_pkg::ALT_SEL1_RST;
      else if (wr_en && sel_alt)
         tx_sel_reg <= pwdata[port_a_pkg::TX_SEL_BIT];
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         global_pu_reg <= port_a_pkg::GLOBAL_PU_RST;
      else if (wr_en && sel_option)
         global_pu_reg <= pwdata[port_a_pkg::GLOBAL_PU_BIT];
   end

   // ==========================================
   // Read data
   // ==========================================
   logic [31:0] rd_word;

   always_comb
   begin
      rd_word = 32'h0000_0000;
      if (sel_value)
         rd_word = {24'h00_0000, pin_digital};
      else if (sel_latch)
         rd_word = {24'h00_0000, latch_reg};
      else if (sel_direction)
         rd_word = {24'h00_0000, direction_reg};
      else if (sel_pullup)
         rd_word = {24'h00_0000, 2'b00, pullup_reg, 5'h00};
      else if (sel_analog)
         rd_word = {27'h000_0000, analog_reg};
      else if (sel_alt)
         rd_word = {31'h0000_0000, tx_sel_reg};
      else if (sel_option)
         rd_word = {24'h00_0000, global_pu_reg, 7'h00};
   end

   // Captured at setup so the word stands when ready is sampled
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         prdata <= 32'h0000_0000;
      else if (rd_setup)
         prdata <= rd_word;
   end

   // ==========================================
   // Digital input and analog switches
   // ==========================================
   assign pin_digital = pin_sync_reg & ~{3'b000, analog_reg};
   assign analog_connect = analog_reg;

   // ==========================================
   // Output priority per pin
   // ==========================================
   logic [7:0] per_en;
   logic [7:0] per_val;

   always_comb
   begin
      per_en  = 8'h00;
      per_val = 8'h00;
      if (periph.spi_two_data_out.en)
         {per_en[0], per_val[0]} = {1'b1, periph.spi_two_data_out.val};

      if (periph.spi_two_select.en)
         {per_en[1], per_val[1]} = {1'b1, periph.spi_two_select.val};

      if (periph.dac_output.en)
         {per_en[2], per_val[2]} = {1'b1, periph.dac_output.val};

      if (periph.sr_latch_out.en)
         {per_en[3], per_val[3]} = {1'b1, periph.sr_latch_out.val};
      else if (periph.capture_compare_three.en)
         {per_en[3], per_val[3]} = {1'b1, periph.capture_compare_three.val};
      else if (periph.comparator_one_out.en)
         {per_en[3], per_val[3]} = {1'b1, periph.comparator_one_out.val};

      if (periph.sr_latch_out_inv.en)
         {per_en[4], per_val[4]} = {1'b1, periph.sr_latch_out_inv.val};
      else if (periph.capture_compare_four.en)
         {per_en[4], per_val[4]} = {1'b1, periph.capture_compare_four.val};
      else if (periph.timer_zero_clock_in.en)
         {per_en[4], per_val[4]} = {1'b1, periph.timer_zero_clock_in.val};
      else if (periph.comparator_two_out.en)
         {per_en[4], per_val[4]} = {1'b1, periph.comparator_two_out.val};

      if (crystal_out_cfg && periph.crystal_out.en)
         {per_en[6], per_val[6]} = {1'b1, periph.crystal_out.val};
      else if (periph.instr_clock_out.en)
         {per_en[6], per_val[6]} = {1'b1, periph.instr_clock_out.val};
      else if (periph.reference_clock_out.en)
         {per_en[6], per_val[6]} = {1'b1, periph.reference_clock_out.val};
      else if (periph.spi_one_data_out.en)
         {per_en[6], per_val[6]} = {1'b1, periph.spi_one_data_out.val};
      else if (periph.pwm_one_out_d.en)
         {per_en[6], per_val[6]} = {1'b1, periph.pwm_one_out_d.val};
      else if (periph.pwm_two_out_b.en)
         {per_en[6], per_val[6]} = {1'b1, periph.pwm_two_out_b.val};

      if (crystal_in_cfg && periph.crystal_in_clock_in.en)
         {per_en[7], per_val[7]} = {1'b1, periph.crystal_in_clock_in.val};
      else if (periph.pwm_one_out_c.en)
         {per_en[7], per_val[7]} = {1'b1, periph.pwm_one_out_c.val};
      else if (periph.capture_compare_two.en)
         {per_en[7], per_val[7]} = {1'b1, periph.capture_compare_two.val};
      else if (periph.pwm_two_out_a.en)
         {per_en[7], per_val[7]} = {1'b1, periph.pwm_two_out_a.val};
   end

   // ==========================================
   // Pad drive, registered
   // ==========================================
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_pin
         always_ff @(posedge clk_sys or negedge rst_n)
         begin
            if (!rst_n)
            begin
               pin_a_out[gi]    <= 1'b0;
               pin_a_oe[gi]     <= 1'b0;
               pin_a_pullup[gi] <= 1'b0;
            end
            else
            begin
               // Analog select plays no part in drive
               pin_a_oe[gi]  <= !direction_reg[gi];
               pin_a_out[gi] <= per_en[gi] ? per_val[gi] : latch_reg[gi];
               if (gi == port_a_pkg::PULLUP_PIN)
                  pin_a_pullup[gi] <= direction_reg[gi] &&
                     (external_reset_enable || (pullup_reg && !global_pu_reg));
               else
                  pin_a_pullup[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // ==========================================
   // Serial function steering to port B
   // ==========================================
   // Unselected pin gets no override; directions untouched
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         pin_b2_override <= '0;
      else
         pin_b2_override <= tx_sel_reg ? '0 : serial_transmit_clock;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         pin_b5_override <= '0;
      else
         pin_b5_override <= tx_sel_reg ? serial_transmit_clock : '0;
   end

endmodule : port_a_io

// ==== port_a_io_properties.sv ====
// Checker: timing relations at the port A block boundary
`timescale 1ns/10ps

module port_a_io_properties
(
   input wire logic                       clk_sys,               // Clock
   input wire logic                       rst_n,                 // Reset
   input wire logic                       psel,                  // Select
   input wire logic                       penable,               // Access
   input wire logic                       pwrite,                // Write
   input wire logic [7:0]                 paddr,                 // Address
   input wire logic [31:0]                prdata,                // Read data
   input wire logic [7:0]                 pin_a_out,             // Drive value
   input wire logic [7:0]                 pin_a_oe,              // Drive enable
   input wire logic [7:0]                 pin_a_pullup,          // Pull-ups
   input wire logic [4:0]                 analog_connect,        // Analog switches
   input wire port_a_pkg::periph_bundle_t periph,                // Peripherals
   input wire logic                       crystal_out_cfg,       // Crystal out on
   input wire logic                       external_reset_enable, // Reset pin on
   input wire port_a_pkg::serial_route_t  serial_transmit_clock, // Serial function
   input wire port_a_pkg::serial_route_t  pin_b2_override,       // B2 override
   input wire port_a_pkg::serial_route_t  pin_b5_override        // B5 override
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   logic rd_acc;
   logic wr_dir;
   assign rd_acc = psel && penable && !pwrite;
   assign wr_dir = psel && penable && pwrite && paddr == port_a_pkg::OFS_DIRECTION;

   // ==========================================
   // Assertions
   // ==========================================
   chk_pin5_undriven: assert property (pin_a_oe[5] == 1'b0)
      else $error("pin five driver enabled");
   chk_dir5_reads_one: assert property (
      rd_acc && paddr == port_a_pkg::OFS_DIRECTION |-> prdata[5] == 1'b1)
      else $error("direction bit five read zero");
   chk_oe_dir_only: assert property ($changed(pin_a_oe) |-> $past(wr_dir, 2))
      else $error("driver enable moved without direction write");
   chk_sel_upper_zero: assert property (
      rd_acc && paddr == port_a_pkg::OFS_ALT_SEL1 |-> prdata[31:1] == 31'h0)
      else $error("select upper bits not zero");
   chk_analog_reads_zero: assert property (
      rd_acc && paddr == port_a_pkg::OFS_VALUE |-> (prdata[4:0] & analog_connect) == 5'h00)
      else $error("analog pin read nonzero");
   chk_pullup_pin_five: assert property ((pin_a_pullup & 8'hdf) == 8'h00)
      else $error("pull-up on pin other than five");
   chk_pullup_vs_out: assert property ((pin_a_pullup & pin_a_oe) == 8'h00)
      else $error("pull-up on driven pin");
   chk_reset_pin_pull: assert property (
      external_reset_enable |=> pin_a_pullup[5])
      else $error("reset pin pull-up missing");
   chk_serial_one_pin: assert property (
      serial_transmit_clock.drive_en |=> pin_b2_override.drive_en != pin_b5_override.drive_en)
      else $error("serial function not on exactly one pin");
   chk_serial_idle: assert property (
      !serial_transmit_clock.drive_en |=> !pin_b2_override.drive_en && !pin_b5_override.drive_en)
      else $error("serial override without request");
   chk_crystal_wins: assert property (
      crystal_out_cfg && periph.crystal_out.en
      |=> pin_a_out[6] == $past(periph.crystal_out.val))
      else $error("crystal output lost pin six");
endmodule : port_a_io_properties

bind port_a_io port_a_io_properties chk (.*);

// ==== port_a_pads.sv ====
// Pad model: resolves port A pin levels from block, outside drivers and pull-ups
`timescale 1ns/10ps

module port_a_pads
(
   input  wire logic       clk_sys, // Clock for floating pattern
   input  wire logic [7:0] pin_out, // Block drive value
   input  wire logic [7:0] pin_oe,  // Block drive enable
   input  wire logic [7:0] pin_pu,  // Block pull-up on
   input  wire logic [7:0] ext_oe,  // Outside driver on
   input  wire logic [7:0] ext_val, // Outside driver level
   output logic      [7:0] pin_lvl  // Resolved level
);
   // Undriven pins wander so a stale level never passes
   logic [7:0] float_reg = 8'h55;
   always @(posedge clk_sys)
      float_reg <= ~float_reg;
   assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
                  | (~pin_oe & ~ext_oe & (pin_pu | float_reg));
endmodule : port_a_pads

// ==== port_a_io_with_output_priority_test.sv ====
// Testbench for port A block: registers, pads, priority and serial routing
`timescale 1ns/10ps

module port_a_io_with_output_priority_test;
   logic                       clk_sys;
   logic                       rst_n = 1'b0;
   logic                       psel = 1'b0;
   logic                       penable = 1'b0;
   logic                       pwrite = 1'b0;
   logic [7:0]                 paddr = 8'h00;
   logic [31:0]                pwdata = 32'h0;
   logic [31:0]                prdata;
   logic                       pready;
   logic                       pslverr;
   logic [7:0]                 pin_a_in, pin_a_out, pin_a_oe, pin_a_pullup;
   logic [4:0]                 analog_connect;
   port_a_pkg::periph_bundle_t periph = '0;
   logic                       crystal_out_cfg = 1'b0;
   logic                       crystal_in_cfg = 1'b0;
   logic                       external_reset_enable = 1'b0;
   port_a_pkg::serial_route_t  serial_transmit_clock = '0;
   port_a_pkg::serial_route_t  pin_b2_override, pin_b5_override;
   logic [7:0]                 ext_oe = 8'h20;
   logic [7:0]                 ext_val = 8'h20;
   logic [31:0]                rdat;
   logic                       err;
   int                         mismatches = 0;
   int                         cmp_count = 0;

   port_a_io dut (.*);
   port_a_pads pads (.clk_sys(clk_sys), .pin_out(pin_a_out), .pin_oe(pin_a_oe),
                     .pin_pu(pin_a_pullup), .ext_oe(ext_oe), .ext_val(ext_val),
                     .pin_lvl(pin_a_in));

   // ==========================================
   // Tasks
   // ==========================================
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         $display("BAD %s expected %h seen %h", nm, exp, got);
         mismatches++;
      end
   endtask : check

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1)
         @(posedge clk_sys);
      // Answer taken at the edge that sees ready
      err  = pslverr;
      rdat = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(nm, rdat, exp);
   endtask : rd

   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : idle

   task automatic wrap_up();
      $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up

   // ==========================================
   // Clock, watchdog, sequence
   // ==========================================
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   initial
   begin
      #200000;
      mismatches++;
      wrap_up();
   end

   initial
   begin
      port_a_pkg::periph_bundle_t p;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      rd("latch", port_a_pkg::OFS_LATCH, 32'h00);
      rd("direction", port_a_pkg::OFS_DIRECTION, 32'hff);
      rd("pullup", port_a_pkg::OFS_PULLUP, 32'h00);
      rd("analog", port_a_pkg::OFS_ANALOG, 32'h1f);
      rd("select", port_a_pkg::OFS_ALT_SEL1, 32'h00);
      rd("option", port_a_pkg::OFS_OPTION, 32'h80);
      wr(8'h1c, 32'hff);
      check("unmapped error", {31'h0, err}, 32'h1);
      rd("unmapped", 8'h1c, 32'h0);
      // Serial function steering
      wr(port_a_pkg::OFS_ALT_SEL1, 32'hffffffff);
      rd("select", port_a_pkg::OFS_ALT_SEL1, 32'h1);
      serial_transmit_clock <= 2'b11;
      idle(2);
      check("b5 route", {30'h0, pin_b5_override}, 32'h3);
      check("b2 idle", {31'h0, pin_b2_override.drive_en}, 32'h0);
      wr(port_a_pkg::OFS_ALT_SEL1, 32'h0);
      idle(2);
      check("b2 route", {30'h0, pin_b2_override}, 32'h3);
      check("b5 idle", {31'h0, pin_b5_override.drive_en}, 32'h0);
      rd("direction kept", port_a_pkg::OFS_DIRECTION, 32'hff);
      // Drivers, latch and pin reads
      wr(port_a_pkg::OFS_DIRECTION, 32'h0);
      rd("direction", port_a_pkg::OFS_DIRECTION, 32'h20);
      wr(port_a_pkg::OFS_LATCH, 32'hff);
      idle(2);
      check("oe", pin_a_oe, 32'hdf);
      check("out", pin_a_out, 32'hdf);
      rd("value analog", port_a_pkg::OFS_VALUE, 32'he0);
      wr(port_a_pkg::OFS_ANALOG, 32'h0);
      check("analog switch", analog_connect, 32'h0);
      rd("value digital", port_a_pkg::OFS_VALUE, 32'hff);
      wr(port_a_pkg::OFS_VALUE, 32'h3c);
      rd("latch", port_a_pkg::OFS_LATCH, 32'h1c);
      rd("value", port_a_pkg::OFS_VALUE, 32'h3c);
      // Pull-ups
      wr(port_a_pkg::OFS_DIRECTION, 32'hff);
      idle(1);
      check("oe off", pin_a_oe, 32'h0);
      wr(port_a_pkg::OFS_OPTION, 32'h0);
      wr(port_a_pkg::OFS_PULLUP, 32'hff);
      rd("pullup", port_a_pkg::OFS_PULLUP, 32'h20);
      check("pullup pad", pin_a_pullup, 32'h20);
      wr(port_a_pkg::OFS_OPTION, 32'h80);
      idle(1);
      check("pullup global", pin_a_pullup, 32'h0);
      external_reset_enable <= 1'b1;
      idle(2);
      check("pullup reset pin", pin_a_pullup, 32'h20);
      external_reset_enable <= 1'b0;
      // Pin six owner as higher sources drop out
      crystal_out_cfg <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         p = '0;
         for (int j = i; j < 6; j++)
            p[19 - 2 * j] = 1'b1;
         p[18 - 2 * i] = 1'b1;
         periph <= p;
         idle(2);
         check("pin6 owner", pin_a_out[6], 32'h1);
      end
      crystal_out_cfg <= 1'b0;
      p = '0;
      p[19:18] = 2'b11;
      periph <= p;
      idle(2);
      check("pin6 crystal off", pin_a_out[6], 32'h0);
      p = '0;
      p[33] = 1'b1;
      p[31:28] = 4'hf;
      periph <= p;
      idle(2);
      check("pin3 owner", pin_a_out[3], 32'h0);
      crystal_in_cfg <= 1'b1;
      p = '0;
      p[7:6] = 2'b10;
      p[5:4] = 2'b11;
      periph <= p;
      idle(2);
      check("pin7 clock in", pin_a_out[7], 32'h0);
      wrap_up();
   end
endmodule : port_a_io_with_output_priority_test
